// [rtl/icm_pkg.sv]
package icm_pkg;
  localparam logic [11:0] ADDR_SLAVE   = 12'hf0b;
  localparam logic [11:0] ADDR_UNLOCK  = 12'hf0c;
  localparam logic [11:0] ADDR_STATUS  = 12'hf0d;
  localparam logic [7:0]  UNLOCK_KEY   = 8'h93;
  localparam logic [15:0] CRC_SEED     = 16'hffff;
  localparam logic [4:0]  CMD_PROGRAM  = 5'h14;
  localparam logic [4:0]  CMD_ERASE    = 5'h06;
  localparam logic [4:0]  CMD_BLANK    = 5'h0d;
  localparam logic [4:0]  CMD_CLR_CRC  = 5'h1a;
  localparam logic [4:0]  CMD_RST_CPU  = 5'h09;
  localparam logic [2:0]  RD_IDX_CMD   = 3'h1;
  localparam logic [2:0]  RD_IDX_CRC_H = 3'h4;
  localparam logic [2:0]  RD_IDX_CRC_L = 3'h5;
  localparam int          ST_PROG_BIT  = 0;
  localparam int          ST_TESTA_BIT = 1;
  localparam int          ST_TESTB_BIT = 2;
  localparam int          ST_WRITER_BIT = 3;
endpackage : icm_pkg

// [rtl/icm_crc_mode.sv]
`timescale 1ns/1ns
module icm_crc_mode
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        cmd_valid,
  input  wire logic [4:0]  cmd_code,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  input  wire logic        byte_is_low_addr,
  input  wire logic        byte_acked,
  input  wire logic        cmd_rd_valid,
  input  wire logic [2:0]  cmd_rd_index,
  output logic      [7:0]  cmd_rd_data,
  output logic      [15:0] crc_value,
  output logic      [6:0]  prog_slave_addr,
  output logic             prog_mode,
  output logic             cpu_restart,
  input  wire logic        chip_reset,
  input  wire logic        strap_pin_nine,
  input  wire logic        strap_pin_eight,
  input  wire logic        selftest_out_pin,
  output logic             test_mode_a,
  output logic             test_mode_b,
  output logic             writer_mode
);

  typedef enum logic [1:0] {ICM_IDLE, ICM_SHIFT} icm_state_e;

  icm_state_e  state_r;
  logic [15:0] crc_r;
  logic [7:0]  shift_r;
  logic [2:0]  bit_cnt_r;
  logic [4:0]  cur_cmd_r;
  logic [6:0]  slave_r;
  logic        prog_r;
  logic        restart_r;
  logic        reset_d_r;
  logic        test_b_r;
  logic [7:0]  rdata_r;
  logic [7:0]  cmd_rd_r;

  icm_state_e  state_nxt;
  logic [15:0] crc_nxt;
  logic [7:0]  shift_nxt;
  logic [2:0]  bit_cnt_nxt;
  logic [4:0]  cur_cmd_nxt;
  logic [6:0]  slave_nxt;
  logic        prog_nxt;
  logic        test_b_nxt;
  logic [7:0]  rdata_nxt;
  logic [7:0]  cmd_rd_nxt;

  wire logic        feedback_bit;
  wire logic        incoming_bit;
  wire logic [15:0] crc_step;
  wire logic        erase_like;
  wire logic        byte_counts;
  wire logic        clr_cmd;
  wire logic        rst_cmd;
  wire logic        latch_cmd;
  wire logic        wr_slave;
  wire logic        wr_unlock;
  wire logic        key_ok;
  wire logic        rd_slave;
  wire logic        rd_status;
  wire logic [7:0]  status_word;
  wire logic [7:0]  slave_word;
  wire logic [7:0]  reg_rd_word;
  wire logic        idx_cmd;
  wire logic        idx_crc_h;
  wire logic        idx_crc_l;
  wire logic [7:0]  cmd_rd_word;
  wire logic        reset_fall;
  wire logic        mode_a_straps;
  wire logic        mode_b_straps;
  wire logic        writer_straps;

  assign incoming_bit = shift_r[7];
  assign feedback_bit = crc_r[15] ^ incoming_bit;
  assign crc_step = {crc_r[14] ^ feedback_bit, crc_r[13:2],
                     crc_r[1] ^ feedback_bit, crc_r[0], feedback_bit};

  assign erase_like = (cur_cmd_r == icm_pkg::CMD_ERASE) ||
                      (cur_cmd_r == icm_pkg::CMD_BLANK);
  // A byte the slave refused while busy must never reach the CRC
  assign byte_counts = byte_valid && byte_acked && !byte_is_low_addr
                       && !erase_like && prog_r;
  assign clr_cmd = cmd_valid && prog_r && (cmd_code == icm_pkg::CMD_CLR_CRC);
  assign rst_cmd = cmd_valid && prog_r && (cmd_code == icm_pkg::CMD_RST_CPU);
  // Clear and restart act at once and are never echoed as the current command
  assign latch_cmd = cmd_valid && (cmd_code != icm_pkg::CMD_CLR_CRC)
                     && (cmd_code != icm_pkg::CMD_RST_CPU);

  assign wr_slave  = reg_wr && (reg_addr == icm_pkg::ADDR_SLAVE);
  assign wr_unlock = reg_wr && (reg_addr == icm_pkg::ADDR_UNLOCK);
  assign key_ok    = (reg_wdata == icm_pkg::UNLOCK_KEY);
  assign rd_slave  = reg_rd && (reg_addr == icm_pkg::ADDR_SLAVE);
  assign rd_status = reg_rd && (reg_addr == icm_pkg::ADDR_STATUS);

  assign status_word[7:4] = 4'h0;
  assign status_word[icm_pkg::ST_PROG_BIT]   = prog_r;
  assign status_word[icm_pkg::ST_TESTA_BIT]  = test_mode_a;
  assign status_word[icm_pkg::ST_TESTB_BIT]  = test_mode_b;
  assign status_word[icm_pkg::ST_WRITER_BIT] = writer_mode;
  assign slave_word  = {1'b0, slave_r};
  // Unmapped and write-only addresses read as zero
  assign reg_rd_word = rd_slave  ? slave_word :
                       rd_status ? status_word : 8'h00;

  assign idx_cmd   = (cmd_rd_index == icm_pkg::RD_IDX_CMD);
  assign idx_crc_h = (cmd_rd_index == icm_pkg::RD_IDX_CRC_H);
  assign idx_crc_l = (cmd_rd_index == icm_pkg::RD_IDX_CRC_L);
  assign cmd_rd_word = idx_cmd   ? {3'h0, cur_cmd_r} :
                       idx_crc_h ? crc_r[15:8] :
                       idx_crc_l ? crc_r[7:0]  : 8'h00;

  // Mode B straps are sampled on the clock, so a reset pulse shorter than a cycle is missed for test_mode_b
  assign reset_fall    = reset_d_r && !chip_reset;
  assign mode_a_straps = strap_pin_nine && !strap_pin_eight && !selftest_out_pin;
  assign mode_b_straps = strap_pin_nine && !strap_pin_eight && selftest_out_pin;
  assign writer_straps = !strap_pin_nine && strap_pin_eight;

  assign cur_cmd_nxt = latch_cmd ? cmd_code : cur_cmd_r;
  assign slave_nxt   = wr_slave ? reg_wdata[6:0] : slave_r;
  // A fresh unlock wins over a restart arriving in the same cycle
  assign prog_nxt    = (wr_unlock && key_ok) ? 1'b1 :
                       rst_cmd ? 1'b0 : prog_r;
  assign test_b_nxt  = reset_fall ? mode_b_straps : test_b_r;
  assign rdata_nxt   = reg_rd_word;
  assign cmd_rd_nxt  = cmd_rd_valid ? cmd_rd_word : cmd_rd_r;

  // A new byte is ignored until the previous one has run out after eight steps
  always_comb
  begin
    state_nxt   = state_r;
    crc_nxt     = crc_r;
    shift_nxt   = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    case (state_r)
      ICM_IDLE:
      begin
        if (byte_counts)
        begin
          state_nxt   = ICM_SHIFT;
          shift_nxt   = byte_data;
          bit_cnt_nxt = 3'h7;
        end
      end
      ICM_SHIFT:
      begin
        crc_nxt     = crc_step;
        shift_nxt   = {shift_r[6:0], 1'b0};
        bit_cnt_nxt = bit_cnt_r - 3'h1;
        if (bit_cnt_r == 3'h0)
        begin
          state_nxt = ICM_IDLE;
        end
      end
      default:
      begin
        state_nxt = ICM_IDLE;
      end
    endcase
    // Clear aborts a shift in progress and beats a byte arriving with it
    if (clr_cmd)
    begin
      state_nxt = ICM_IDLE;
      crc_nxt   = icm_pkg::CRC_SEED;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= ICM_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      crc_r <= icm_pkg::CRC_SEED;
    end
    else
    begin
      crc_r <= crc_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shift_r <= 8'h00;
    end
    else
    begin
      shift_r <= shift_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bit_cnt_r <= 3'h0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cur_cmd_r <= 5'h00;
    end
    else
    begin
      cur_cmd_r <= cur_cmd_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      slave_r <= 7'h00;
    end
    else
    begin
      slave_r <= slave_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prog_r <= 1'b0;
    end
    else
    begin
      prog_r <= prog_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      restart_r <= 1'b0;
    end
    else
    begin
      restart_r <= rst_cmd;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reset_d_r <= 1'b0;
    end
    else
    begin
      reset_d_r <= chip_reset;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      test_b_r <= 1'b0;
    end
    else
    begin
      test_b_r <= test_b_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_rd_r <= 8'h00;
    end
    else
    begin
      cmd_rd_r <= cmd_rd_nxt;
    end
  end

  assign test_mode_a = chip_reset && mode_a_straps;
  assign writer_mode = chip_reset && writer_straps;
  assign test_mode_b = test_b_r;
  assign reg_rdata   = rdata_r;
  assign cmd_rd_data = cmd_rd_r;
  assign crc_value   = crc_r;
  assign prog_slave_addr = slave_r;
  assign prog_mode   = prog_r;
  assign cpu_restart = restart_r;

endmodule : icm_crc_mode

// [verification/icm_chk.sv]
`timescale 1ns/1ns
module icm_chk
(
  input logic        clk,
  input logic        srst,
  input logic [11:0] reg_addr,
  input logic [7:0]  reg_wdata,
  input logic        reg_wr,
  input logic        cmd_valid,
  input logic [4:0]  cmd_code,
  input logic [15:0] crc_value,
  input logic        prog_mode,
  input logic        cpu_restart,
  input logic        chip_reset,
  input logic        strap_pin_nine,
  input logic        strap_pin_eight,
  input logic        selftest_out_pin,
  input logic        test_mode_a,
  input logic        test_mode_b,
  input logic        writer_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire unlock_w = reg_wr && reg_addr == icm_pkg::ADDR_UNLOCK;
  wire cmd_on_w = cmd_valid && prog_mode;
  a_seed_reset: assert property ($fell(srst) |-> crc_value == 16'hffff)
    else $error("crc not seeded");
  a_clear_crc: assert property (cmd_on_w && cmd_code == icm_pkg::CMD_CLR_CRC |=> &crc_value)
    else $error("crc not cleared");
  a_unlock_key: assert property (unlock_w && reg_wdata == 8'h93 |=> prog_mode)
    else $error("unlock missed");
  a_wrong_key: assert property (unlock_w && reg_wdata != 8'h93 && !prog_mode |=> !prog_mode)
    else $error("bad key accepted");
  a_restart_pulse: assert property (cmd_on_w && cmd_code == icm_pkg::CMD_RST_CPU
    |=> cpu_restart ##1 !cpu_restart)
    else $error("restart pulse wrong");
  // Nine idle cycles let any shift begun before the drop run out
  a_crc_hold: assert property (!prog_mode [*8] ##1 !prog_mode |=> $stable(crc_value))
    else $error("crc moved while idle");
  a_test_a_mode: assert property (test_mode_a ==
    (chip_reset && strap_pin_nine && !strap_pin_eight && !selftest_out_pin))
    else $error("test mode a wrong");
  a_writer_mode: assert property (writer_mode ==
    (chip_reset && !strap_pin_nine && strap_pin_eight))
    else $error("writer mode wrong");
  a_mode_b_latch: assert property ($fell(chip_reset) && strap_pin_nine && !strap_pin_eight
    && selftest_out_pin |=> test_mode_b)
    else $error("test mode b missed");
endmodule : icm_chk
bind icm_crc_mode icm_chk i_icm_chk (.*);

// [verification/icm_host.sv]
`timescale 1ns/1ns
module icm_host
(
  input  logic       clk,
  input  logic [7:0] cmd_rd_data,
  output logic       cmd_valid,
  output logic [4:0] cmd_code,
  output logic       byte_valid,
  output logic [7:0] byte_data,
  output logic       byte_is_low_addr,
  output logic       byte_acked,
  output logic       cmd_rd_valid,
  output logic [2:0] cmd_rd_index
);
  initial
  begin
    {cmd_valid, byte_valid, cmd_rd_valid} = 3'h0;
    {cmd_code, byte_data, byte_is_low_addr, byte_acked, cmd_rd_index} = 18'h0;
  end
  task automatic cmd(input logic [4:0] c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
  endtask : cmd
  // The released data byte shows the inverse so a stale value cannot pass
  task automatic data(input logic [7:0] d, input logic lo, input logic ak);
    @(posedge clk);
    byte_valid       <= 1'b1;
    byte_data        <= d;
    byte_is_low_addr <= lo;
    byte_acked       <= ak;
    @(posedge clk);
    byte_valid       <= 1'b0;
    byte_data        <= ~d;
    repeat (9) @(posedge clk);
  endtask : data
  task automatic rd(input logic [2:0] i, output logic [7:0] v);
    @(posedge clk);
    cmd_rd_valid <= 1'b1;
    cmd_rd_index <= i;
    @(posedge clk);
    cmd_rd_valid <= 1'b0;
    #1 v = cmd_rd_data;
  endtask : rd
endmodule : icm_host

// [verification/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  logic        clk, srst, reg_wr, reg_rd, cmd_valid, byte_valid, byte_is_low_addr, byte_acked;
  logic        cmd_rd_valid, prog_mode, cpu_restart, chip_reset, strap_pin_nine, strap_pin_eight;
  logic        selftest_out_pin, test_mode_a, test_mode_b, writer_mode;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, byte_data, cmd_rd_data, v;
  logic [7:0]  kv [3] = '{8'hf6, 8'h28, 8'hc3};
  logic [4:0]  cmd_code;
  logic [2:0]  cmd_rd_index;
  logic [15:0] crc_value, exp_crc;
  logic [6:0]  prog_slave_addr;
  logic [9:0]  r;
  int          n_fail = 0, n_compared = 0, cyc = 0;
  icm_crc_mode i_icm_crc_mode (.*);
  icm_host     i_icm_host (.*);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic f;
    for (int i = 7; i >= 0; i--)
    begin
      f = c[15] ^ d[i];
      c = {c[14] ^ f, c[13:2], c[1] ^ f, c[0], f};
    end
    return c;
  endfunction : crc_byte
  task automatic rw(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 v = reg_rdata;
  endtask : rw
  initial
  begin
    void'($urandom(32'hb09e));
    {srst, reg_wr, reg_rd, chip_reset, reg_addr, reg_wdata} = 24'h800000;
    {strap_pin_nine, strap_pin_eight, selftest_out_pin} = 3'h0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    i_icm_host.data(8'h5a, 1'b0, 1'b1);
    chk(crc_value, 16'hffff);
    rw(1'b1, icm_pkg::ADDR_UNLOCK, 8'h92);
    rw(1'b1, icm_pkg::ADDR_SLAVE, 8'h2d);
    rw(1'b1, icm_pkg::ADDR_UNLOCK, icm_pkg::UNLOCK_KEY);
    rw(1'b0, icm_pkg::ADDR_STATUS, 8'h00);
    chk({8'h0, v}, 16'h0001);
    rw(1'b0, 12'h0ff, 8'h00);
    chk({v, 1'b0, prog_slave_addr}, 16'h002d);
    rw(1'b0, icm_pkg::ADDR_SLAVE, 8'h00);
    chk({8'h0, v}, 16'h002d);
    i_icm_host.cmd(icm_pkg::CMD_PROGRAM);
    exp_crc = icm_pkg::CRC_SEED;
    for (int i = 0; i < 40; i++)
    begin
      r = (i < 3) ? {2'b10, kv[i]} : 10'($urandom);
      i_icm_host.data(r[7:0], r[8], r[9]);
      if (r[9] && !r[8])
        exp_crc = crc_byte(exp_crc, r[7:0]);
      chk(crc_value, exp_crc);
      if (i == 2)
        chk(crc_value, 16'h7031);
    end
    i_icm_host.rd(icm_pkg::RD_IDX_CRC_H, v);
    chk({8'h0, v}, {8'h0, exp_crc[15:8]});
    i_icm_host.rd(icm_pkg::RD_IDX_CRC_L, v);
    chk({8'h0, v}, {8'h0, exp_crc[7:0]});
    i_icm_host.rd(icm_pkg::RD_IDX_CMD, v);
    chk({8'h0, v}, {11'h0, icm_pkg::CMD_PROGRAM});
    for (int k = 0; k < 2; k++)
    begin
      i_icm_host.cmd(k ? icm_pkg::CMD_BLANK : icm_pkg::CMD_ERASE);
      i_icm_host.data(8'h3c, 1'b0, 1'b1);
      chk(crc_value, exp_crc);
    end
    i_icm_host.cmd(icm_pkg::CMD_CLR_CRC);
    #1 chk(crc_value, 16'hffff);
    i_icm_host.cmd(icm_pkg::CMD_RST_CPU);
    #1 chk({15'h0, cpu_restart}, 16'h0001);
    @(posedge clk);
    #1 chk({15'h0, prog_mode}, 16'h0000);
    for (int m = 0; m < 18; m++)
    begin
      @(posedge clk);
      {chip_reset, strap_pin_nine, strap_pin_eight, selftest_out_pin} <= 4'(m < 16 ? m : 21 - m);
      repeat (2) @(posedge clk);
      #1 chk({14'h0, test_mode_a, writer_mode}, {14'h0, m == 12, m[4:1] == 4'b0101});
    end
    chk({15'h0, test_mode_b}, 16'h0001);
    report_and_stop();
  end
endmodule : tb_top
